/* hdl/lpf_top.sv */
// Function code interpreter and status word for a line printer controller.
// Assumes a connected channel gives one-cycle code and status strobes.
// What this block does
// - 0023 cancels end-of-operation interrupt, replies.
// - Abnormal interrupt on not-ready or print error.
// - Abnormal interrupt holds until listed clears.
// - 0025 cancels abnormal interrupt, replies.
// - 0030 sets postprint, clears selections, eject, suppress.
// - Postprint levels advance after print until hole.
// - Level 1 is top, 12 last line.
// - 0050 enters preprint without motion, suppresses spacing.
// - Preprint levels move paper until selected hole.
// - Status request returns sum of condition bits.
// - Status bits follow the fixed twelve-bit layout.
// - Ready sets on start with all conditions.
// - No print or spacing code unless ready.
// - Busy during write, print and paper motion.
// - Program error sets on illegal character, clears.
// - Paper-out bit follows printer paper sense.
// - Last-line and level-9 bits clear on motion.
// - Memory busy from load start until printed.
// - Interrupt bits need selection and their condition.
// - Print error sets on any of five faults.
// - Print error clears on channel busy, reset, clears.
// - Operating codes need ready, not busy; else reject.
`timescale 1ns/100ps
module lpf_top
  import lpf_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Channel
  input  wire logic                   connected,
  input  wire logic                   func_valid,
  input  wire logic [11:0]            func_code,
  input  wire logic                   status_req,
  input  wire logic                   clear_channel,
  input  wire logic                   master_clear,
  input  wire logic                   chan_busy_new,
  output logic                        reply,
  output logic                        reject,
  output logic                        status_valid,
  output logic [ST_W-1:0]             status_word,
  // Operator switches and printer sense
  input  wire logic                   start_sw,
  input  wire logic                   stop_sw,
  input  wire logic                   check_reset_sw,
  input  wire logic                   err_override,
  input  wire logic                   power_ok,
  input  wire logic                   interlock_ok,
  input  wire logic                   tape_ok,
  input  wire logic                   paper_ok,
  // Print path
  input  wire logic                   write_active,
  input  wire logic                   print_cycle,
  input  wire logic                   load_begin,
  input  wire logic                   line_printed,
  input  wire logic                   illegal_char_stored,
  input  wire logic [4:0]             print_fault,
  output logic                        print_ok,
  // Carriage
  input  wire logic                   line_step,
  input  wire logic [TAPE_LEVELS-1:0] tape_hole,
  output logic                        paper_advance
);

  typedef struct packed {
    lpf_mv_t        mv;
    logic [3:0]     tgt;
    logic [3:0]     post_sel;
    logic           cmd_motion;
    logic           mem_in_motion;
    logic           eop_wait;
    logic           preprint;
    logic           supp_pend;
    logic           sel_rnb;
    logic           sel_eop;
    logic           sel_abn;
    logic           ready;
    logic           busy;
    logic           paper_out;
    logic           last_line;
    logic           lvl9;
    logic           mem_busy;
    logic           reply;
    logic           reject;
    logic           stat_valid;
    logic [ST_W-1:0] stat_word;
    logic           advance;
  } lpf_st_t;

  lpf_st_t st_reg;
  lpf_st_t st_next;

  logic clr_all;
  logic fv;
  logic is_oper;
  logic is_nonop;
  logic oper_ok;
  logic acc;
  logic done;
  logic hit;
  logic fault_any;
  logic prg_err;
  logic prt_err;
  logic int_rnb;
  logic int_eop;
  logic int_abn;
  logic set_rnb;
  logic set_eop;
  logic set_abn;
  logic clr_rnb;
  logic clr_eop;
  logic clr_abn;
  logic post_start;
  logic [ST_W-1:0] word;

  // Decode helpers
  assign clr_all   = clear_channel | master_clear;
  assign fv        = func_valid & connected;
  assign fault_any = |print_fault;
  assign is_nonop  = (func_code == FC_RELEASE) |
                     ((func_code >= FC_SEL_RNB) & (func_code <= FC_CLR_ABN));
  assign is_oper   = (func_code == FC_SUPPRESS) |
                     ((func_code >= FC_POST_MODE) & (func_code <= FC_POST_L12)) |
                     ((func_code >= FC_PRE_MODE) & (func_code <= FC_PRE_L12));
  assign oper_ok   = st_reg.ready & ~st_reg.busy & (st_reg.mv == LPF_IDLE);
  assign acc       = fv & (is_nonop | (is_oper & oper_ok));
  assign done      = (st_reg.mv == LPF_MOVE) & hit;
  assign post_start = line_printed & ~st_reg.preprint & st_reg.ready &
                      ~st_reg.supp_pend & (st_reg.mv == LPF_IDLE);

  // Motion end detector
  lpf_stop_det #(
    .LEVELS (TAPE_LEVELS)
  ) u_stop (
    .level (st_reg.tgt),
    .step  (line_step),
    .holes (tape_hole),
    .hit   (hit)
  );

  // Interrupt set and clear terms
  assign set_rnb = st_reg.sel_rnb & st_reg.ready & ~st_reg.busy;
  assign set_eop = st_reg.sel_eop &
                   ((done & st_reg.cmd_motion & ~st_reg.mem_in_motion) |
                    (line_printed & st_reg.eop_wait));
  assign set_abn = st_reg.sel_abn &
                   ((done & ~st_reg.ready) |
                    (line_printed & ~st_reg.ready) |
                    (line_printed & (prt_err | fault_any) & ~err_override));
  assign clr_rnb = clr_all | (acc & ((func_code == FC_SEL_RNB) |
                   (func_code == FC_CLR_RNB) | (func_code == FC_RELEASE)));
  assign clr_eop = clr_all | (acc & ((func_code == FC_SEL_EOP) |
                   (func_code == FC_CLR_EOP) | (func_code == FC_RELEASE)));
  assign clr_abn = clr_all | (acc & ((func_code == FC_SEL_ABN) |
                   (func_code == FC_CLR_ABN) | (func_code == FC_RELEASE)));

  // Sticky interrupt and error flags
  lpf_flag u_rnb (.clk(clk), .rst(rst), .set(set_rnb), .clr(clr_rnb), .flag(int_rnb));
  lpf_flag u_eop (.clk(clk), .rst(rst), .set(set_eop), .clr(clr_eop), .flag(int_eop));
  lpf_flag u_abn (.clk(clk), .rst(rst), .set(set_abn), .clr(clr_abn), .flag(int_abn));
  lpf_flag u_prg (
    .clk  (clk),
    .rst  (rst),
    .set  (illegal_char_stored),
    .clr  (load_begin | clr_all | (acc & (func_code == FC_RELEASE))),
    .flag (prg_err)
  );
  lpf_flag u_prt (
    .clk  (clk),
    .rst  (rst),
    .set  (fault_any),
    .clr  (chan_busy_new | check_reset_sw | clr_all),
    .flag (prt_err)
  );

  // Status word assembly, one bit per condition so the sum is an OR
  always_comb begin
    word             = ST_RESET;
    word[ST_READY]   = st_reg.ready;
    word[ST_BUSY]    = st_reg.busy;
    word[ST_PRG_ERR] = prg_err;
    word[ST_NO_PAP]  = st_reg.paper_out;
    word[ST_LAST]    = st_reg.last_line;
    word[ST_LVL9]    = st_reg.lvl9;
    word[ST_MEM_BSY] = st_reg.mem_busy;
    word[ST_INT_RNB] = int_rnb;
    word[ST_INT_EOP] = int_eop;
    word[ST_INT_ABN] = int_abn;
    word[ST_PRT_ERR] = prt_err;
  end

  // Next-state logic
  always_comb begin
    st_next            = st_reg;
    st_next.reply      = acc;
    st_next.reject     = fv & ~acc;
    st_next.stat_valid = status_req & connected;
    if (status_req & connected)
      st_next.stat_word = word;
    // Ready latch
    if (~(power_ok & interlock_ok & tape_ok & paper_ok) | stop_sw)
      st_next.ready = 1'b0;
    else if (start_sw)
      st_next.ready = 1'b1;
    st_next.paper_out = ~paper_ok;
    // Buffer memory busy
    if (load_begin)
      st_next.mem_busy = 1'b1;
    else if (line_printed)
      st_next.mem_busy = 1'b0;
    // Function codes
    if (acc) begin
      case (func_code)
        FC_RELEASE: begin
          st_next.sel_rnb = 1'b0;
          st_next.sel_eop = 1'b0;
          st_next.sel_abn = 1'b0;
        end
        FC_SEL_RNB: st_next.sel_rnb = 1'b1;
        FC_CLR_RNB: st_next.sel_rnb = 1'b0;
        FC_SEL_EOP: st_next.sel_eop = 1'b1;
        FC_CLR_EOP: st_next.sel_eop = 1'b0;
        FC_SEL_ABN: st_next.sel_abn = 1'b1;
        FC_CLR_ABN: st_next.sel_abn = 1'b0;
        FC_SUPPRESS: st_next.supp_pend = 1'b1;
        FC_POST_MODE: begin
          st_next.preprint  = 1'b0;
          st_next.post_sel  = LVL_NONE;
          st_next.supp_pend = 1'b0;
        end
        FC_PRE_MODE: st_next.preprint = 1'b1;
        default: begin
          if (func_code <= FC_POST_L12) begin
            st_next.preprint = 1'b0;
            st_next.post_sel = 4'(func_code - FC_POST_L1) + LVL_TOP;
          end else begin
            st_next.preprint      = 1'b1;
            st_next.tgt           = 4'(func_code - FC_PRE_L1) + LVL_TOP;
            st_next.cmd_motion    = 1'b1;
            st_next.mem_in_motion = 1'b0;
            st_next.eop_wait      = 1'b0;
            st_next.mv            = LPF_MOVE;
            st_next.advance       = 1'b1;
            st_next.last_line     = 1'b0;
            st_next.lvl9          = 1'b0;
          end
        end
      endcase
    end
    // Paper motion sequencer
    case (st_reg.mv)
      LPF_IDLE: begin
        if (line_printed & st_reg.eop_wait)
          st_next.eop_wait = 1'b0;
        if (line_printed & st_reg.supp_pend & ~st_reg.preprint)
          st_next.supp_pend = 1'b0;
        if (post_start) begin
          st_next.tgt        = st_reg.post_sel;
          st_next.cmd_motion = 1'b0;
          st_next.mv         = LPF_MOVE;
          st_next.advance    = 1'b1;
          st_next.last_line  = 1'b0;
          st_next.lvl9       = 1'b0;
        end
      end
      LPF_MOVE: begin
        if (load_begin)
          st_next.mem_in_motion = 1'b1;
        if (line_step) begin
          st_next.last_line = tape_hole[LVL_LAST - LVL_TOP];
          st_next.lvl9      = tape_hole[LVL_NINE - LVL_TOP];
        end
        if (done) begin
          st_next.mv       = LPF_IDLE;
          st_next.advance  = 1'b0;
          st_next.post_sel = LVL_NONE;
          st_next.eop_wait = st_reg.cmd_motion & st_reg.mem_in_motion;
        end
      end
      default: begin
        st_next.mv      = LPF_IDLE;
        st_next.advance = 1'b0;
      end
    endcase
    st_next.busy = write_active | print_cycle | (st_next.mv == LPF_MOVE);
    // Channel clear and master clear drop modes and selections
    if (clr_all) begin
      st_next.sel_rnb   = 1'b0;
      st_next.sel_eop   = 1'b0;
      st_next.sel_abn   = 1'b0;
      st_next.preprint  = 1'b0;
      st_next.supp_pend = 1'b0;
      st_next.eop_wait  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.mv        <= LPF_IDLE;
      st_reg.stat_word <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign reply         = st_reg.reply;
  assign reject        = st_reg.reject;
  assign status_valid  = st_reg.stat_valid;
  assign status_word   = st_reg.stat_word;
  assign paper_advance = st_reg.advance;
  assign print_ok      = st_reg.ready;

  // Checks
  AST_EOP_CLR: assert property (@(posedge clk) disable iff (rst)
    fv && func_code == FC_CLR_EOP |=> reply && !st_reg.sel_eop)
    else $error("clear end-of-operation not honoured");
  AST_ABN_HOLD: assert property (@(posedge clk) disable iff (rst)
    int_abn && !clr_abn |=> int_abn)
    else $error("abnormal interrupt dropped early");
  AST_ABN_CLR: assert property (@(posedge clk) disable iff (rst)
    fv && func_code == FC_CLR_ABN && !set_abn |=> reply && !st_reg.sel_abn && !int_abn)
    else $error("clear abnormal interrupt not honoured");
  AST_POST_MODE: assert property (@(posedge clk) disable iff (rst)
    acc && func_code == FC_POST_MODE |=>
      st_reg.post_sel == LVL_NONE && !st_reg.preprint && !st_reg.supp_pend)
    else $error("postprint mode did not clear selections");
  AST_SEL_DROP: assert property (@(posedge clk) disable iff (rst)
    done |=> st_reg.post_sel == LVL_NONE && !paper_advance)
    else $error("selection kept after motion stop");
  AST_PRE_NOMOVE: assert property (@(posedge clk) disable iff (rst)
    acc && func_code == FC_PRE_MODE && !paper_advance && !clr_all |=>
      st_reg.preprint && !paper_advance)
    else $error("preprint mode moved paper");
  AST_PRE_MOVE: assert property (@(posedge clk) disable iff (rst)
    acc && func_code >= FC_PRE_L1 && func_code <= FC_PRE_L12 && !clr_all |=>
      paper_advance && st_reg.preprint && st_reg.busy)
    else $error("preprint level did not start motion");
  AST_REFUSE: assert property (@(posedge clk) disable iff (rst)
    fv && is_oper && !st_reg.ready |=> reject && !reply)
    else $error("spacing code accepted while not ready");
  AST_STATUS: assert property (@(posedge clk) disable iff (rst)
    status_req && connected |=> status_valid && !status_word[ST_SPARE] &&
      status_word[ST_READY] == $past(st_reg.ready))
    else $error("status word wrong");
  AST_PRT_CLR: assert property (@(posedge clk) disable iff (rst)
    check_reset_sw && !fault_any |=> !prt_err)
    else $error("print error not cleared");

  COV_PRE: cover property (@(posedge clk) disable iff (rst) done && st_reg.cmd_motion);
  COV_ABN: cover property (@(posedge clk) disable iff (rst) set_abn);
  COV_STAT: cover property (@(posedge clk) disable iff (rst) status_valid && status_word != 0);

endmodule : lpf_top

/* hdl/lpf_pkg.sv */
// Package for the line printer function and status block.
// Assumes octal function codes arrive as 12-bit words on the channel.
package lpf_pkg;

  // Function codes (octal values written in hex)
  localparam logic [11:0] FC_RELEASE   = 12'h000;
  localparam logic [11:0] FC_SUPPRESS  = 12'h006;
  localparam logic [11:0] FC_SEL_RNB   = 12'h010;
  localparam logic [11:0] FC_CLR_RNB   = 12'h011;
  localparam logic [11:0] FC_SEL_EOP   = 12'h012;
  localparam logic [11:0] FC_CLR_EOP   = 12'h013;
  localparam logic [11:0] FC_SEL_ABN   = 12'h014;
  localparam logic [11:0] FC_CLR_ABN   = 12'h015;
  localparam logic [11:0] FC_POST_MODE = 12'h018;
  localparam logic [11:0] FC_POST_L1   = 12'h019;
  localparam logic [11:0] FC_POST_L12  = 12'h024;
  localparam logic [11:0] FC_PRE_MODE  = 12'h028;
  localparam logic [11:0] FC_PRE_L1    = 12'h029;
  localparam logic [11:0] FC_PRE_L12   = 12'h034;

  // Status word bit positions
  localparam int ST_READY   = 0;
  localparam int ST_BUSY    = 1;
  localparam int ST_PRG_ERR = 2;
  localparam int ST_NO_PAP  = 3;
  localparam int ST_LAST    = 4;
  localparam int ST_LVL9    = 5;
  localparam int ST_MEM_BSY = 6;
  localparam int ST_INT_RNB = 7;
  localparam int ST_INT_EOP = 8;
  localparam int ST_INT_ABN = 9;
  localparam int ST_PRT_ERR = 10;
  localparam int ST_SPARE   = 11;
  localparam int ST_W       = 12;

  // Tape levels; level zero means plain single space
  localparam int          TAPE_LEVELS = 12;
  localparam logic [3:0]  LVL_NONE    = 4'h0;
  localparam logic [3:0]  LVL_TOP     = 4'h1;
  localparam logic [3:0]  LVL_NINE    = 4'h9;
  localparam logic [3:0]  LVL_LAST    = 4'hC;
  localparam logic [11:0] ST_RESET    = 12'h000;

  // Paper motion sequencer states
  typedef enum logic [1:0] {
    LPF_IDLE = 2'b01,
    LPF_MOVE = 2'b10
  } lpf_mv_t;

endpackage : lpf_pkg

/* hdl/lpf_flag.sv */
// Sticky flag with set priority over clear.
// Assumes set and clear are single-clock qualified terms.
`timescale 1ns/100ps
module lpf_flag
  import lpf_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic set,
  input  wire logic clr,
  // Flag
  output logic      flag
);

  typedef struct packed {
    logic f;
  } lpf_flag_st_t;

  lpf_flag_st_t st_reg;
  lpf_flag_st_t st_next;

  // A set in the clearing cycle is kept
  always_comb begin
    st_next = st_reg;
    if (set)
      st_next.f = 1'b1;
    else if (clr)
      st_next.f = 1'b0;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign flag = st_reg.f;

endmodule : lpf_flag

/* hdl/lpf_stop_det.sv */
// Detects the line step that ends a paper motion.
// Assumes holes are sampled at the print position on each step.
`timescale 1ns/100ps
module lpf_stop_det
  import lpf_pkg::*;
#(
  parameter int LEVELS = TAPE_LEVELS
)
(
  // Motion target, zero for single space
  input  wire logic [3:0]        level,
  // Tape reader
  input  wire logic              step,
  input  wire logic [LEVELS-1:0] holes,
  // Result
  output logic                   hit
);

  // Single space stops on any step, otherwise on the selected hole
  always_comb begin
    if (level == LVL_NONE)
      hit = step;
    else
      hit = step & holes[level - LVL_TOP];
  end

endmodule : lpf_stop_det

/* test/lpf_chan_model.sv */
// Channel model: issues function codes and status requests.
// Assumes answers come registered one clock after the request edge.
`timescale 1ns/100ps
module lpf_chan_model (
  // Clock
  input  wire logic        clk,
  // Requests
  output logic             func_valid,
  output logic [11:0]      func_code,
  output logic             status_req,
  // Answers
  input  wire logic        reply,
  input  wire logic        reject,
  input  wire logic        status_valid,
  input  wire logic [11:0] status_word
);
  // Idle channel
  initial begin
    func_valid = 1'b0;
    func_code  = 12'hFFF;
    status_req = 1'b0;
  end

  // One function code; answer taken one clock after the code
  task automatic send(input logic [11:0] c, output logic [1:0] a);
    @(posedge clk);
    #1 func_valid = 1'b1;
    func_code = c;
    @(posedge clk);
    #1 a = {reply, reject};
    func_valid = 1'b0;
    func_code = ~c;  // Released lines keep no stale code
  endtask : send

  // One status request
  task automatic get(output logic [11:0] w, output logic v);
    @(posedge clk);
    #1 status_req = 1'b1;
    @(posedge clk);
    #1 v = status_valid;
    w = status_word;
    status_req = 1'b0;
  endtask : get
endmodule : lpf_chan_model

/* test/test_lpf_top.sv */
// Self-checking bench for the printer function and status block.
// Assumes the channel model file is compiled first.
`timescale 1ns/100ps
module test_lpf_top
  import lpf_pkg::*;
;
  localparam logic [1:0] RPY = 2'b10;
  localparam logic [1:0] REJ = 2'b01;
  logic        clk, rst, connected, power_ok, interlock_ok, tape_ok, paper_ok;
  logic        write_active, func_valid, status_req, reply, reject, status_valid;
  logic        print_ok, paper_advance, err_override, print_cycle;
  logic [9:0]  pls;
  logic [4:0]  print_fault;
  logic [11:0] func_code, status_word, tape_hole;
  logic [31:0] r;
  int          fails, cmp_count, cyc;

  // Design and channel model
  lpf_top lpf_top_inst (.clk(clk), .rst(rst), .connected(connected),
    .func_valid(func_valid), .func_code(func_code), .status_req(status_req),
    .clear_channel(pls[0]), .master_clear(pls[1]), .chan_busy_new(pls[2]),
    .reply(reply), .reject(reject), .status_valid(status_valid),
    .status_word(status_word), .start_sw(pls[3]), .stop_sw(pls[4]),
    .check_reset_sw(pls[5]), .err_override(err_override), .power_ok(power_ok),
    .interlock_ok(interlock_ok), .tape_ok(tape_ok), .paper_ok(paper_ok),
    .write_active(write_active), .print_cycle(print_cycle), .load_begin(pls[6]),
    .line_printed(pls[7]), .illegal_char_stored(pls[8]),
    .print_fault(print_fault), .print_ok(print_ok), .line_step(pls[9]),
    .tape_hole(tape_hole), .paper_advance(paper_advance));
  lpf_chan_model lpf_chan_model_inst (.clk(clk), .func_valid(func_valid),
    .func_code(func_code), .status_req(status_req), .reply(reply),
    .reject(reject), .status_valid(status_valid), .status_word(status_word));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      complete_run();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected answer to a code; ok means ready, idle and still
  function automatic logic [1:0] exp_ans(input logic [11:0] c, input logic ok);
    if (c == FC_RELEASE || (c >= FC_SEL_RNB && c <= FC_CLR_ABN)) return RPY;
    if (c == FC_SUPPRESS || (c >= FC_POST_MODE && c <= FC_POST_L12) ||
        (c >= FC_PRE_MODE && c <= FC_PRE_L12)) return ok ? RPY : REJ;
    return REJ;
  endfunction : exp_ans

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic pulse(input int i);
    @(posedge clk);
    #1 pls[i] = 1'b1;
    @(posedge clk);
    #1 pls[i] = 1'b0;
  endtask : pulse

  task automatic step(input logic [11:0] h);
    tape_hole = h;
    pulse(9);
    tape_hole = ~h;
  endtask : step

  task automatic code(input logic [11:0] c, input logic [1:0] e);
    logic [1:0] a;
    lpf_chan_model_inst.send(c, a);
    check({11'h0, a}, {11'h0, e});
  endtask : code

  // Status bits under mask m; bit 11 always checked as zero
  task automatic stchk(input logic [11:0] m, input logic [11:0] e);
    logic [11:0] w;
    logic        v;
    lpf_chan_model_inst.get(w, v);
    check({v, w & (m | 12'h800)}, {1'b1, e & m});
  endtask : stchk

  task automatic adv(input logic e);
    check({12'h0, paper_advance}, {12'h0, e});
  endtask : adv

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    logic [11:0] c;
    logic [3:0]  lv;
    rst = 1'b1; connected = 1'b0; pls = '0; print_fault = '0;
    power_ok = 1'b1; interlock_ok = 1'b1; tape_ok = 1'b1; paper_ok = 1'b1;
    write_active = 1'b0; tape_hole = '0; r = 32'h000114B9;
    err_override = 1'b0;
    print_cycle = 1'b0;
    fails = 0; cmp_count = 0; cyc = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    code(FC_CLR_EOP, 2'b00);
    connected = 1'b1;
    stchk(12'hFFF, 12'h000);
    code(FC_CLR_EOP, RPY);
    // Random codes while not ready
    repeat (40) begin
      r = lfsr(r);
      c = {6'h00, r[5:0]};
      if (c >= 12'h001 && c <= 12'h005) c = 12'h040;
      code(c, exp_ans(c, 1'b0));
    end
    // Abnormal end: raise, then each way of dropping it
    for (int k = 0; k < 5; k++) begin
      code(FC_SEL_ABN, RPY);
      pulse(7);
      stchk(12'h200, 12'h200);
      case (k)
        0: code(FC_SEL_ABN, RPY);
        1: code(FC_CLR_ABN, RPY);
        2: code(FC_RELEASE, RPY);
        default: pulse(k - 3);
      endcase
      stchk(12'h200, 12'h000);
    end
    // Ready needs paper sense plus start
    paper_ok = 1'b0;
    pulse(3);
    stchk(12'h009, 12'h008);
    paper_ok = 1'b1;
    pulse(3);
    stchk(12'h009, 12'h001);
    check({12'h0, print_ok}, 13'h1);
    // Preprint levels with end-of-operation interrupt
    for (int k = 0; k < 3; k++) begin
      r = lfsr(r);
      lv = (k == 0) ? 4'h9 : (k == 1) ? 4'hC : 4'(r[3:0] % 12 + 1);
      code(FC_SEL_EOP, RPY);
      code(FC_PRE_L1 + 12'(lv - 1), RPY);
      adv(1'b1);
      stchk(12'h132, 12'h002);
      code(FC_POST_MODE, REJ);
      step(r[15:4] & ~(12'h001 << (lv - 1)));
      adv(1'b1);
      // Last pass loads memory during motion, so the interrupt waits for the print
      if (k == 2) pulse(6);
      step(12'h001 << (lv - 1));
      adv(1'b0);
      if (k == 2) stchk(12'h100, 12'h000);
      if (k == 2) pulse(7);
      stchk(12'h132, {4'h1, 2'b00, lv == 4'h9, lv == 4'hC, 4'h0});
    end
    code(FC_CLR_EOP, RPY);
    stchk(12'h100, 12'h000);
    // Postprint spacing, preprint mode and suppress
    code(FC_SUPPRESS, RPY);
    code(FC_POST_MODE, RPY);
    pulse(7);
    adv(1'b1);
    step(12'h000);
    adv(1'b0);
    code(FC_PRE_MODE, RPY);
    adv(1'b0);
    pulse(7);
    adv(1'b0);
    code(FC_POST_L1 + 12'h002, RPY);
    pulse(7);
    step(12'h000);
    adv(1'b1);
    step(12'h004);
    adv(1'b0);
    pulse(7);
    step(12'h000);
    adv(1'b0);
    code(FC_SUPPRESS, RPY);
    pulse(7);
    adv(1'b0);
    // Write busy, then stop
    write_active = 1'b1;
    stchk(12'h002, 12'h002);
    code(FC_POST_MODE, REJ);
    write_active = 1'b0;
    pulse(4);
    stchk(12'h001, 12'h000);
    code(FC_PRE_L1, REJ);
    // Memory busy and program error
    pulse(6);
    stchk(12'h040, 12'h040);
    pulse(8);
    stchk(12'h004, 12'h004);
    pulse(7);
    stchk(12'h040, 12'h000);
    pulse(6);
    stchk(12'h004, 12'h000);
    pulse(8);
    code(FC_RELEASE, RPY);
    stchk(12'h004, 12'h000);
    // Each print fault, cleared each documented way
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      #1 print_fault = 5'h01 << k;
      @(posedge clk);
      #1 print_fault = 5'h00;
      stchk(12'h400, 12'h400);
      pulse((k % 4 == 0) ? 2 : (k % 4 == 1) ? 5 : k % 4 - 2);
      stchk(12'h400, 12'h000);
    end
    // Print error raises abnormal end only with override off; print cycle is busy
    pulse(3);
    code(FC_PRE_MODE, RPY);
    for (int k = 0; k < 2; k++) begin
      err_override = (k == 0);
      print_cycle  = 1'b1;
      code(FC_SEL_ABN, RPY);
      stchk(12'h002, 12'h002);
      print_fault = 5'h04;
      pulse(7);
      print_fault = 5'h00;
      print_cycle = 1'b0;
      stchk(12'h602, (k == 0) ? 12'h400 : 12'h600);
      pulse(5);
    end
    complete_run();
  end
endmodule : test_lpf_top
